/* File: hdl/brd_pkg.sv */
// Purpose: Constants and carrier types for the bridge register-space decoder.
// Assumes: Primary-side requests arrive already decoded as cycles from the PCI engine.
// Notes: Functional notes below.
package brd_pkg;
  localparam logic [8:0]  CFG_SPACE_BYTES = 9'h100;
  localparam logic [7:0]  CFG_HDR_LIMIT   = 8'h80;
  localparam logic [7:0]  CFG_BAR_OFS     = 8'h10;
  localparam logic [7:0]  CFG_SECBUS_OFS  = 8'h18;
  localparam logic [7:0]  CFG_MISC_OFS    = 8'h80;
  localparam logic [7:0]  CFG_PWR_OFS     = 8'h84;
  localparam logic [11:0] WIN_C16_BASE    = 12'h800;
  localparam logic [15:0] LEG_INDEX_PORT  = 16'h03E0;
  localparam logic [15:0] LEG_DATA_PORT   = 16'h03E2;
  localparam int          MISC_CARD_AUDIO_LINE_BIT   = 0;
  localparam int          MISC_LEGACY_BIT = 1;
  localparam logic [31:0] BAR_RESET       = 32'h0000_0000;
  localparam logic [31:0] BAR_MASK        = 32'hFFFF_F000;
  localparam logic [3:0]  PWR_RESET       = 4'h3;

  typedef enum logic [2:0] {
    BRD_TGT_NONE = 3'b000,
    BRD_TGT_CFG  = 3'b001,
    BRD_TGT_C32  = 3'b010,
    BRD_TGT_C16  = 3'b011,
    BRD_TGT_FWD  = 3'b100,
    BRD_TGT_IDX  = 3'b101
  } brd_target_t;

  typedef enum logic [1:0] {
    BRD_CYC_CFG0 = 2'b00,
    BRD_CYC_CFG1 = 2'b01,
    BRD_CYC_MEM  = 2'b10,
    BRD_CYC_IO   = 2'b11
  } brd_cyc_t;

  typedef struct packed {
    logic       valid;
    brd_cyc_t   cyc;
    logic       write;
    logic       primary;
    logic [31:0] addr;
    logic [31:0] wdata;
  } brd_req_t;

  typedef struct packed {
    logic        hit;
    brd_target_t target;
    logic [11:0] reg_ofs;
    logic [31:0] fwd_addr;
    logic [31:0] rdata;
  } brd_rsp_t;

  typedef struct packed {
    logic [31:0] bar;
    logic [7:0]  sec_bus;
    logic [7:0]  misc;
    logic [3:0]  pwr;
    logic [7:0]  index;
    brd_rsp_t    rsp;
  } brd_state_t;
endpackage

/* File: hdl/brd_decode.sv */
// Purpose: Register-space decode and configuration routing for the card bridge.
// Assumes: One primary request per cycle; card audio and suspend arrive asynchronously.
// Notes: Answer is registered, one cycle after the request.
`timescale 1ns/1ns
module brd_decode (
  // Clock and resets
  input  wire logic          clk_sys,
  input  wire logic          nrst,
  input  wire logic          pci_rst_n,
  // Shared suspend / speaker pin
  input  wire logic          susp_pin_i,
  output logic               susp_pin_o,
  output logic               susp_pin_oe,
  input  wire logic          card_audio_line,
  // Primary request and answer
  input  brd_pkg::brd_req_t  req,
  output brd_pkg::brd_rsp_t  rsp,
  // Power switch
  output logic               card_5v_switch_en_n,
  output logic               card_3v3_switch_en_n,
  output logic               prog_supply_sel0,
  output logic               prog_supply_sel1,
  output logic               hw_suspend_n
);
  // Decode map seen from the primary side:
  //   cfg0 from primary : own 256-byte space; standard header below 0x80,
  //                       socket control words from 0x80 upward
  //   cfg1 on our bus   : rewritten as a type 0 cycle for the card
  //   mem in window     : lower 2 KB wide-card, upper 2 KB narrow-card
  //   io 0x3E0 / 0x3E2  : index / data pair, only while legacy mode is on
  // Anything else leaves hit low so that another agent may claim it.
  // A request that meets an active PCI reset outside suspend is dropped, not queued, so
  // the clear never races a write in the same cycle.

  localparam int SYNC_N   = 3;
  localparam int SYNC_SUS = 0;
  localparam int SYNC_AUD = 1;
  localparam int SYNC_RST = 2;

  brd_pkg::brd_state_t s_q;
  brd_pkg::brd_state_t s_d;
  logic [SYNC_N-1:0]   sync_in;
  logic [SYNC_N-1:0]   sync_out;
  logic                susp_s;
  logic                audio_s;
  logic                prst_s;
  logic                card_audio_line_en;
  logic                soft_rst;
  logic [4:0]          fwd_dev;
  logic [31:0]         fwd_idsel;
  logic [31:0]         fwd_reg;
  logic [31:0]         fwd_addr;

  // The decode slices fixed fields out of these; refuse other values
  if (brd_pkg::CFG_SPACE_BYTES != 9'h100) begin : g_bad_cfg_size
    $error("configuration space must be 256 bytes");
  end
  if (brd_pkg::CFG_HDR_LIMIT != 8'h80) begin : g_bad_hdr_limit
    $error("header must end half way through configuration space");
  end
  if (brd_pkg::WIN_C16_BASE != 12'h800) begin : g_bad_win_split
    $error("narrow-card half must start half way through the window");
  end

  // All three pins are asynchronous and idle high; a reset value of ones
  // keeps a false suspend, audio edge or PCI reset from following nrst
  assign sync_in = {pci_rst_n, card_audio_line, susp_pin_i};

  for (genvar i = 0; i < SYNC_N; i++) begin : g_sync
    logic [1:0] ff_q;
    always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
        ff_q <= 2'b11;
      end else begin
        ff_q <= {ff_q[0], sync_in[i]};
      end
    end
    assign sync_out[i] = ff_q[1];
  end

  assign susp_s  = sync_out[SYNC_SUS];
  assign audio_s = sync_out[SYNC_AUD];
  assign prst_s  = sync_out[SYNC_RST];

  assign card_audio_line_en      = s_q.misc[brd_pkg::MISC_CARD_AUDIO_LINE_BIT];
  // Pin is an input unless speaker routing is on, then suspend reads inactive
  assign hw_suspend_n = card_audio_line_en | susp_s;
  assign susp_pin_oe  = card_audio_line_en;
  // Card audio is active low; the pin carries it as a positive pulse train
  assign susp_pin_o   = card_audio_line_en & ~audio_s;
  // PCI reset only acts while not suspended; state otherwise held
  assign soft_rst     = ~prst_s & hw_suspend_n;

  // Type 1 to type 0: the device number becomes a one-hot IDSEL line from
  // bit 16 up, the register word keeps its place and the type bits clear.
  // Devices above 15 have no line to drive and so select nobody.
  assign fwd_dev = req.addr[15:11];
  for (genvar b = 0; b < 32; b++) begin : g_idsel
    if (b >= 16) begin : g_line
      assign fwd_idsel[b] = (fwd_dev == 5'(b - 16));
    end else begin : g_none
      assign fwd_idsel[b] = 1'b0;
    end
  end
  assign fwd_reg  = {21'h00_0000, req.addr[10:2], 2'b00};
  assign fwd_addr = fwd_idsel | fwd_reg;

  always_comb begin
    logic [7:0] cofs;
    cofs = req.addr[7:0];
    s_d = s_q;
    s_d.rsp = '0;
    if (soft_rst) begin
      s_d.bar     = brd_pkg::BAR_RESET;
      s_d.sec_bus = '0;
      s_d.misc    = '0;
      s_d.pwr     = brd_pkg::PWR_RESET;
      s_d.index   = '0;
    end else if (req.valid) begin
      case (req.cyc)
        brd_pkg::BRD_CYC_CFG0: begin
          if (req.primary) begin
            s_d.rsp.hit     = 1'b1;
            s_d.rsp.target  = brd_pkg::BRD_TGT_CFG;
            s_d.rsp.reg_ofs = {4'h0, cofs};
            if (cofs < brd_pkg::CFG_HDR_LIMIT) begin
              if (cofs == brd_pkg::CFG_BAR_OFS) begin
                if (req.write) s_d.bar = req.wdata & brd_pkg::BAR_MASK;
                s_d.rsp.rdata = s_q.bar;
              end else if (cofs == brd_pkg::CFG_SECBUS_OFS) begin
                if (req.write) s_d.sec_bus = req.wdata[15:8];
                s_d.rsp.rdata = {16'h0000, s_q.sec_bus, 8'h00};
              end
            end else begin
              if (cofs == brd_pkg::CFG_MISC_OFS) begin
                if (req.write) s_d.misc = req.wdata[7:0];
                s_d.rsp.rdata = {24'h0000_00, s_q.misc};
              end else if (cofs == brd_pkg::CFG_PWR_OFS) begin
                if (req.write) s_d.pwr = req.wdata[3:0];
                s_d.rsp.rdata = {28'h000_0000, s_q.pwr};
              end
            end
          end
        end
        brd_pkg::BRD_CYC_CFG1: begin
          if (req.primary && req.addr[23:16] == s_q.sec_bus) begin
            s_d.rsp.hit      = 1'b1;
            s_d.rsp.target   = brd_pkg::BRD_TGT_FWD;
            s_d.rsp.fwd_addr = fwd_addr;
          end
        end
        // Window claims nothing until software has placed it away from zero
        brd_pkg::BRD_CYC_MEM: begin
          if (s_q.bar != brd_pkg::BAR_RESET &&
              (req.addr & brd_pkg::BAR_MASK) == s_q.bar) begin
            s_d.rsp.hit     = 1'b1;
            s_d.rsp.reg_ofs = req.addr[11:0];
            s_d.rsp.target  = (req.addr[11:0] >= brd_pkg::WIN_C16_BASE) ?
                              brd_pkg::BRD_TGT_C16 : brd_pkg::BRD_TGT_C32;
          end
        end
        // The data port only names a narrow-card offset; the socket logic
        // behind the window does the actual access
        brd_pkg::BRD_CYC_IO: begin
          if (s_q.misc[brd_pkg::MISC_LEGACY_BIT]) begin
            if (req.addr[15:0] == brd_pkg::LEG_INDEX_PORT) begin
              s_d.rsp.hit    = 1'b1;
              s_d.rsp.target = brd_pkg::BRD_TGT_IDX;
              if (req.write) s_d.index = req.wdata[7:0];
              s_d.rsp.rdata  = {24'h0000_00, s_q.index};
            end else if (req.addr[15:0] == brd_pkg::LEG_DATA_PORT) begin
              s_d.rsp.hit     = 1'b1;
              s_d.rsp.target  = brd_pkg::BRD_TGT_C16;
              s_d.rsp.reg_ofs = brd_pkg::WIN_C16_BASE | {4'h0, s_q.index};
            end
          end
        end
        default: s_d.rsp = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_q.bar     <= brd_pkg::BAR_RESET;
      s_q.sec_bus <= 8'h00;
      s_q.misc    <= 8'h00;
      s_q.pwr     <= brd_pkg::PWR_RESET;
      s_q.index   <= 8'h00;
      s_q.rsp     <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Answer stands for exactly one cycle after the request
  assign rsp = s_q.rsp;

  // Switch enables are active low at the pins; a set bit turns a supply on
  assign card_5v_switch_en_n  = ~s_q.pwr[0];
  assign card_3v3_switch_en_n = ~s_q.pwr[1];
  assign prog_supply_sel0     = s_q.pwr[2];
  assign prog_supply_sel1     = s_q.pwr[3];
endmodule

/* File: dv/brd_chk_properties.sv */
// Purpose: Port-level checks of the bridge decoder.
// Assumes: Answer registered one cycle after the request.
// Notes: Bound to brd_decode at the foot of this file.
`timescale 1ns/1ns
module brd_chk (
  // Clock and reset
  input wire logic              clk_sys,
  input wire logic              nrst,
  // Observed ports
  input wire brd_pkg::brd_req_t req,
  input wire brd_pkg::brd_rsp_t rsp,
  input wire logic              susp_pin_oe,
  input wire logic              hw_suspend_n,
  input wire logic              prog_supply_sel1
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  property p_pri; req.valid && req.cyc < 2 && !req.primary |=> !rsp.hit; endproperty
  a_pri: assert property (p_pri) else $error("config answered off primary");
  property p_lat; rsp.hit |-> $past(req.valid); endproperty
  a_lat: assert property (p_lat) else $error("answer without request");
  property p_c32; rsp.target == brd_pkg::BRD_TGT_C32 |-> !rsp.reg_ofs[11]; endproperty
  a_c32: assert property (p_c32) else $error("wide card offset in upper half");
  property p_c16; rsp.target == brd_pkg::BRD_TGT_C16 |-> rsp.reg_ofs[11]; endproperty
  a_c16: assert property (p_c16) else $error("narrow card offset in lower half");
  property p_cfg; rsp.target == brd_pkg::BRD_TGT_CFG |-> rsp.reg_ofs[11:8] == 4'h0; endproperty
  a_cfg: assert property (p_cfg) else $error("config offset beyond space");
  property p_io; req.valid && req.cyc == brd_pkg::BRD_CYC_IO
    && req.addr[15:0] != brd_pkg::LEG_INDEX_PORT
    && req.addr[15:0] != brd_pkg::LEG_DATA_PORT |=> !rsp.hit; endproperty
  a_io: assert property (p_io) else $error("stray port answered");
  property p_fwd; rsp.target == brd_pkg::BRD_TGT_FWD |-> $past(req.cyc) == 1; endproperty
  a_fwd: assert property (p_fwd) else $error("forward from wrong cycle");
  property p_hold; !hw_suspend_n && !req.valid |=> $stable(prog_supply_sel1); endproperty
  a_hold: assert property (p_hold) else $error("state lost in suspend");
  property p_spk; susp_pin_oe |-> hw_suspend_n; endproperty
  a_spk: assert property (p_spk) else $error("suspend seen while pin driven");
endmodule
bind brd_decode brd_chk brd_chk_inst (.clk_sys, .nrst, .req, .rsp, .susp_pin_oe,
  .hw_suspend_n, .prog_supply_sel1);

/* File: dv/brd_host.sv */
// Purpose: Primary-bus host that issues decoded cycles.
// Assumes: One request per call, one cycle long.
// Notes: Idle fields are scrambled so stale values are never trusted.
`timescale 1ns/1ns
module brd_host (
  // Clock
  input wire logic          clk_sys,
  // Request to the decoder
  output brd_pkg::brd_req_t req
);
  initial req = '0;
  task automatic issue(input logic [1:0] c, input logic p, input logic [31:0] a, d);
    @(posedge clk_sys);
    #1;
    req = {1'b1, brd_pkg::brd_cyc_t'(c), 1'b1, p, a, d};
    @(posedge clk_sys);
    #1;
    req = {1'b0, brd_pkg::brd_cyc_t'(c), 1'b0, p, ~a, ~d};
  endtask
  // Primary-side read; the answer carries the value held before this cycle
  task automatic fetch(input logic [1:0] c, input logic [31:0] a);
    @(posedge clk_sys);
    #1;
    req = {1'b1, brd_pkg::brd_cyc_t'(c), 1'b0, 1'b1, a, 32'h0000_0000};
    @(posedge clk_sys);
    #1;
    req = {1'b0, brd_pkg::brd_cyc_t'(c), 1'b0, 1'b1, ~a, 32'hFFFF_FFFF};
  endtask
endmodule

/* File: dv/testbench.sv */
// Purpose: Self-checking bench for the bridge decoder.
// Assumes: 20 MHz clock; inputs move 1 ns after the edge.
// Notes: The host model issues every request.
`timescale 1ns/1ns
module testbench;
  logic              clk_sys = 0, nrst = 0, pci_rst_n = 1, ext_n = 1, audio = 1;
  logic              s_o, s_oe, v5_n, v3_n, sel0, sel1, s_n;
  brd_pkg::brd_req_t req;
  brd_pkg::brd_rsp_t rsp;
  int                mismatches = 0, compares = 0, cyc = 0;
  always #25 clk_sys = ~clk_sys;
  brd_host brd_host_inst (.clk_sys, .req);
  brd_decode brd_decode_inst (.clk_sys, .nrst, .pci_rst_n, .susp_pin_i(s_oe ? s_o : ext_n),
    .susp_pin_o(s_o), .susp_pin_oe(s_oe), .card_audio_line(audio), .req, .rsp,
    .card_5v_switch_en_n(v5_n), .card_3v3_switch_en_n(v3_n), .prog_supply_sel0(sel0),
    .prog_supply_sel1(sel1), .hw_suspend_n(s_n));
  task automatic stop_test;
    if (mismatches == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk_sys) if (++cyc == 2000) begin
    mismatches++;
    stop_test();
  end
  task automatic chk(input string n, input logic [31:0] e, g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic go(input logic [1:0] c, input logic p, input logic [31:0] a, d,
                    input logic h, input logic [2:0] t, input logic [31:0] o);
    brd_host_inst.issue(c, p, a, d);
    chk("hit", h, rsp.hit);
    if (h) chk("target", t, rsp.target);
    if (h && t != 5) chk("offset", o, t == 4 ? rsp.fwd_addr : {20'h0, rsp.reg_ofs});
  endtask
  task automatic t_read;
    brd_host_inst.fetch(0, 8'h10);
    chk("bar", 32'hABCD_E000, rsp.rdata);
    brd_host_inst.fetch(0, 8'h18);
    chk("secbus", 32'h0000_0500, rsp.rdata);
    brd_host_inst.fetch(3, 16'h03E0);
    chk("index", 32'h0000_0005, rsp.rdata);
    brd_host_inst.fetch(0, 8'h84);
    chk("power", 32'h0000_0003, rsp.rdata);
  endtask
  task automatic t_susp;
    go(0, 1, 8'h84, 4'hC, 1, 1, 8'h84);
    chk("supply", 4'hF, {v5_n, v3_n, sel0, sel1});
    go(0, 1, 8'h80, 4'h3, 1, 1, 8'h80);
    audio = 0;
    repeat (3) @(posedge clk_sys);
    #1;
    chk("speaker", 2'h3, {s_oe, s_o});
    audio = 1;
    repeat (3) @(posedge clk_sys);
    #1;
    chk("quiet", 2'h2, {s_oe, s_o});
    go(0, 1, 8'h80, 4'h2, 1, 1, 8'h80);
    chk("pin_off", 2'h0, {s_oe, s_o});
    ext_n = 0;
    repeat (3) @(posedge clk_sys);
    #1;
    pci_rst_n = 0;
    repeat (4) @(posedge clk_sys);
    #1;
    pci_rst_n = 1;
    chk("held", 4'hF, {v5_n, v3_n, sel0, sel1});
    ext_n = 1;
    repeat (3) @(posedge clk_sys);
    #1;
    pci_rst_n = 0;
    repeat (4) @(posedge clk_sys);
    #1;
    pci_rst_n = 1;
    chk("cleared", 4'h0, {v5_n, v3_n, sel0, sel1});
    go(3, 1, 16'h03E0, 8'h00, 0, 0, 0);
  endtask
  task automatic t_rst;
    go(0, 1, 8'h80, 4'h1, 1, 1, 8'h80);
    chk("spk_on", 1'b1, s_oe);
    nrst = 0;
    repeat (2) @(posedge clk_sys);
    #1;
    nrst = 1;
    chk("spk_reset", 1'b0, s_oe);
    chk("rsp_reset", 1'b0, rsp.hit);
    go(0, 1, 8'h10, 32'h0000_0000, 1, 1, 8'h10);
  endtask
  initial begin
    repeat (4) @(posedge clk_sys);
    #1;
    nrst = 1;
    go(0, 1, 8'h10, 32'hABCD_E123, 1, 1, 8'h10);
    go(0, 0, 8'h10, 8'h00, 0, 0, 0);
    go(0, 1, 8'hFC, 8'h00, 1, 1, 8'hFC);
    go(2, 1, 32'hABCD_E804, 0, 1, 3, 12'h804);
    go(2, 1, 32'hABCD_E010, 0, 1, 2, 12'h010);
    go(2, 1, 32'hABCD_F010, 0, 0, 0, 0);
    go(0, 1, 8'h18, 16'h0500, 1, 1, 8'h18);
    go(1, 1, 32'h0005_100C, 0, 1, 4, 32'h0004_000C);
    go(1, 1, 32'h0006_100C, 0, 0, 0, 0);
    go(1, 0, 32'h0005_100C, 0, 0, 0, 0);
    go(3, 1, 16'h03E0, 8'h05, 0, 0, 0);
    go(0, 1, 8'h80, 4'h2, 1, 1, 8'h80);
    go(3, 1, 16'h03E0, 8'h05, 1, 5, 0);
    go(3, 1, 16'h03E2, 8'h00, 1, 3, 12'h805);
    go(3, 1, 16'h03E4, 8'h00, 0, 0, 0);
    t_read();
    t_susp();
    t_rst();
    stop_test();
  end
endmodule
